// file: rtl/tx_gate_and_fullscale_regs.sv
`timescale 1ns/1ps
module tx_gate_and_fullscale_regs
  import tx_gate_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       sclk_in,
  input  wire logic       csb_n_in,
  input  wire logic       sdi_in,
  input  wire logic       tx_gate_pin_in,
  output logic            sdo_out,
  output logic            sdo_oe_out,
  output logic            input_gate_out,
  output logic            output_gate_out,
  output logic            nco_reset_select_out,
  output logic [9:0]      fullscale_code_out,
  output logic [1:0]      bias_powerdown_out,
  output logic [5:0]      phase_trim_out
);
  import tx_gate_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_pulse;
  logic [DATA_W-1:0] rd_data;
  logic [7:0]        tx_gate_control_reg;
  logic [7:0]        dac_bias_powerdown_reg;
  logic [7:0]        fullscale_current_low_reg;
  logic [7:0]        fullscale_current_high_reg;
  logic [7:0]        clock_phase_trim_reg;
  logic              pin_meta_reg;
  logic              pin_sync_reg;
  logic [9:0]        fullscale_code;
  logic              input_gate_next;
  logic              output_gate_next;
  logic [9:0]        fullscale_next;

  serial_port_slave u_serial_port_slave (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .sclk_in     (sclk_in),
    .csb_n_in    (csb_n_in),
    .sdi_in      (sdi_in),
    .rd_data_in  (rd_data),
    .addr_out    (addr),
    .wr_data_out (wr_data),
    .wr_pulse_out(wr_pulse),
    .sdo_out     (sdo_out),
    .sdo_oe_out  (sdo_oe_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are held at zero
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tx_gate_control_reg <= TX_GATE_CONTROL_RESET;
    else if (wr_pulse && addr == TX_GATE_CONTROL_ADDR)
      tx_gate_control_reg <= wr_data & TX_GATE_CONTROL_MASK;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      dac_bias_powerdown_reg <= BIAS_POWERDOWN_RESET;
    else if (wr_pulse && addr == DAC_BIAS_POWERDOWN_ADDR)
      dac_bias_powerdown_reg <= wr_data & BIAS_POWERDOWN_MASK;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      fullscale_current_low_reg  <= FULLSCALE_LOW_RESET;
      fullscale_current_high_reg <= FULLSCALE_HIGH_RESET;
    end
    else if (wr_pulse)
    begin
      if (addr == FULLSCALE_CURRENT_LOW_ADDR)
        fullscale_current_low_reg <= wr_data & FULLSCALE_LOW_MASK;
      if (addr == FULLSCALE_CURRENT_HIGH_ADDR)
        fullscale_current_high_reg <= wr_data;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      clock_phase_trim_reg <= PHASE_TRIM_RESET;
    else if (wr_pulse && addr == CLOCK_PHASE_TRIM_ADDR)
      clock_phase_trim_reg <= wr_data & PHASE_TRIM_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (addr)
      TX_GATE_CONTROL_ADDR:        rd_data = tx_gate_control_reg;
      DAC_BIAS_POWERDOWN_ADDR:     rd_data = dac_bias_powerdown_reg;
      FULLSCALE_CURRENT_LOW_ADDR:  rd_data = fullscale_current_low_reg;
      FULLSCALE_CURRENT_HIGH_ADDR: rd_data = fullscale_current_high_reg;
      CLOCK_PHASE_TRIM_ADDR:       rd_data = clock_phase_trim_reg;
      default:                     rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate pin is asynchronous to clk_in
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= tx_gate_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Analog side turns this into 32 mA * code / 1023 + 8 mA
  assign fullscale_code = {fullscale_current_high_reg, fullscale_current_low_reg[1:0]};

  always_comb
  begin
    input_gate_next = tx_gate_control_reg[INPUT_GATE_SELECT_BIT] ? pin_sync_reg
                    : tx_gate_control_reg[REG_INPUT_GATE_BIT];
    output_gate_next = tx_gate_control_reg[OUTPUT_GATE_SELECT_BIT] ? pin_sync_reg
                     : tx_gate_control_reg[REG_OUTPUT_GATE_BIT];
    // Pin low under pin control drops to minimum current, not a hard off
    if (tx_gate_control_reg[FULLSCALE_SELECT_BIT] && !pin_sync_reg)
      fullscale_next = FULLSCALE_GATED_CODE;
    else
      fullscale_next = fullscale_code;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come from flops
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      input_gate_out       <= 1'b0;
      output_gate_out      <= 1'b0;
      nco_reset_select_out <= 1'b0;
      fullscale_code_out   <= 10'h000;
      bias_powerdown_out   <= 2'h3;
      phase_trim_out       <= 6'h00;
    end
    else
    begin
      input_gate_out       <= input_gate_next;
      output_gate_out      <= output_gate_next;
      nco_reset_select_out <= tx_gate_control_reg[NCO_RESET_SELECT_BIT];
      fullscale_code_out   <= fullscale_next;
      bias_powerdown_out   <= dac_bias_powerdown_reg[1:0];
      phase_trim_out       <= clock_phase_trim_reg[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  in_gate_pin_a: assert property (
    tx_gate_control_reg[INPUT_GATE_SELECT_BIT] && pin_sync_reg
      ##0 tx_gate_control_reg[INPUT_GATE_SELECT_BIT] |=> input_gate_out)
    else $error("input gate ignores pin");

  // Sampled reset in the antecedents skips the edge that releases reset,
  // where the outputs still hold their reset values
  in_gate_reg_a: assert property (
    nrst_in && !tx_gate_control_reg[INPUT_GATE_SELECT_BIT] |=>
      input_gate_out == $past(tx_gate_control_reg[REG_INPUT_GATE_BIT]))
    else $error("input gate ignores register bit");

  out_gate_a: assert property (
    nrst_in |=> output_gate_out == ($past(tx_gate_control_reg[OUTPUT_GATE_SELECT_BIT])
      ? $past(pin_sync_reg) : $past(tx_gate_control_reg[REG_OUTPUT_GATE_BIT])))
    else $error("output gate source wrong");

  fs_pin_a: assert property (
    tx_gate_control_reg[FULLSCALE_SELECT_BIT] && !pin_sync_reg |=>
      fullscale_code_out == FULLSCALE_GATED_CODE)
    else $error("full-scale not gated by pin");

  fs_code_a: assert property (
    nrst_in && (!tx_gate_control_reg[FULLSCALE_SELECT_BIT] || pin_sync_reg) |=>
      fullscale_code_out == {$past(fullscale_current_high_reg),
                             $past(fullscale_current_low_reg[1:0])})
    else $error("full-scale code assembly wrong");

  bias_write_a: assert property (
    wr_pulse && addr == DAC_BIAS_POWERDOWN_ADDR |=> ##1
      bias_powerdown_out == $past(wr_data[1:0], 2))
    else $error("bias power-down write lost");

  bias_reset_a: assert property (
    $rose(nrst_in) |-> bias_powerdown_out == 2'h3)
    else $error("bias not powered down at reset");

  low_reserved_a: assert property (
    fullscale_current_low_reg[7:2] == 6'h00)
    else $error("reserved full-scale bits set");

  pin_select_c: cover property (
    tx_gate_control_reg[INPUT_GATE_SELECT_BIT] ##1 $rose(input_gate_out));
  fs_write_c: cover property (wr_pulse && addr == FULLSCALE_CURRENT_HIGH_ADDR);
  read_c: cover property ($rose(sdo_oe_out));

endmodule // tx_gate_and_fullscale_regs

// file: rtl/tx_gate_pkg.sv
package tx_gate_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 24;
  localparam int INSTR_BITS = 16;
  localparam logic [4:0] INSTR_LAST_CNT = 5'h10;
  localparam logic [4:0] FRAME_LAST_CNT = 5'h18;

  // Register offsets
  localparam logic [ADDR_W-1:0] TX_GATE_CONTROL_ADDR      = 15'h003f;
  localparam logic [ADDR_W-1:0] DAC_BIAS_POWERDOWN_ADDR   = 15'h0040;
  localparam logic [ADDR_W-1:0] FULLSCALE_CURRENT_LOW_ADDR  = 15'h0041;
  localparam logic [ADDR_W-1:0] FULLSCALE_CURRENT_HIGH_ADDR = 15'h0042;
  localparam logic [ADDR_W-1:0] CLOCK_PHASE_TRIM_ADDR     = 15'h007f;

  // Field positions in transmit_gate_control
  localparam int REG_OUTPUT_GATE_BIT    = 7;
  localparam int REG_INPUT_GATE_BIT     = 6;
  localparam int NCO_RESET_SELECT_BIT   = 3;
  localparam int OUTPUT_GATE_SELECT_BIT = 2;
  localparam int INPUT_GATE_SELECT_BIT  = 1;
  localparam int FULLSCALE_SELECT_BIT   = 0;
  localparam logic [7:0] TX_GATE_CONTROL_MASK = 8'hcf;

  // Other field masks
  localparam logic [7:0] BIAS_POWERDOWN_MASK = 8'h03;
  localparam logic [7:0] FULLSCALE_LOW_MASK  = 8'h03;
  localparam logic [7:0] PHASE_TRIM_MASK     = 8'h3f;

  // Reset values
  localparam logic [7:0] TX_GATE_CONTROL_RESET  = 8'hc0;
  localparam logic [7:0] BIAS_POWERDOWN_RESET   = 8'h03;
  localparam logic [7:0] FULLSCALE_LOW_RESET    = 8'h03;
  localparam logic [7:0] FULLSCALE_HIGH_RESET   = 8'hff;
  localparam logic [7:0] PHASE_TRIM_RESET       = 8'h00;

  // Code driven while the pin holds full-scale control and is low
  localparam logic [9:0] FULLSCALE_GATED_CODE = 10'h000;

endpackage

// file: rtl/serial_port_slave.sv
`timescale 1ns/1ps
module serial_port_slave
  import tx_gate_pkg::*;
(
  input  wire logic                           clk_in,
  input  wire logic                           nrst_in,
  input  wire logic                           sclk_in,
  input  wire logic                           csb_n_in,
  input  wire logic                           sdi_in,
  input  wire logic [tx_gate_pkg::DATA_W-1:0] rd_data_in,
  output logic      [tx_gate_pkg::ADDR_W-1:0] addr_out,
  output logic      [tx_gate_pkg::DATA_W-1:0] wr_data_out,
  output logic                                wr_pulse_out,
  output logic                                sdo_out,
  output logic                                sdo_oe_out
);
  import tx_gate_pkg::*;

  logic [2:0]  sclk_meta_reg;
  logic [1:0]  csb_meta_reg;
  logic [1:0]  sdi_meta_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] in_sr_reg;
  logic [7:0]  out_sr_reg;
  logic        read_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        active;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops before use; bit 2 of sclk is for edge detection and for the sclk-high check on the read load
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sclk_meta_reg <= 3'h0;
      csb_meta_reg  <= 2'h3;
      sdi_meta_reg  <= 2'h0;
    end
    else
    begin
      sclk_meta_reg <= {sclk_meta_reg[1:0], sclk_in};
      csb_meta_reg  <= {csb_meta_reg[0], csb_n_in};
      sdi_meta_reg  <= {sdi_meta_reg[0], sdi_in};
    end
  end

  assign active    = !csb_meta_reg[1];
  assign sclk_rise = sclk_meta_reg[1] && !sclk_meta_reg[2];
  assign sclk_fall = !sclk_meta_reg[1] && sclk_meta_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Frame: R/W bit, 15 address bits, 8 data bits, MSB first
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bit_cnt_reg  <= 5'h00;
      in_sr_reg    <= 16'h0000;
      addr_out     <= '0;
      read_reg     <= 1'b0;
      wr_data_out  <= '0;
      wr_pulse_out <= 1'b0;
      out_sr_reg   <= 8'h00;
    end
    else
    begin
      wr_pulse_out <= 1'b0;
      if (!active)
      begin
        bit_cnt_reg <= 5'h00;
        read_reg    <= 1'b0;
      end
      else if (sclk_rise && bit_cnt_reg != FRAME_LAST_CNT)
      begin
        in_sr_reg   <= {in_sr_reg[14:0], sdi_meta_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == INSTR_LAST_CNT - 5'h01)
        begin
          addr_out <= {in_sr_reg[13:0], sdi_meta_reg[1]};
          read_reg <= in_sr_reg[14];
        end
        if (bit_cnt_reg == FRAME_LAST_CNT - 5'h01 && !read_reg)
        begin
          wr_data_out  <= {in_sr_reg[6:0], sdi_meta_reg[1]};
          wr_pulse_out <= 1'b1;
        end
      end
      // Cleared between frames so an aborted read cannot block the next load
      if (!active)
        out_sr_reg <= 8'h00;
      // Load one cycle after the address settles so the read mux sees it
      else if (read_reg && bit_cnt_reg == INSTR_LAST_CNT && sclk_meta_reg[1]
               && sclk_meta_reg[2] && out_sr_reg == 8'h00 && sdo_oe_out == 1'b0)
        out_sr_reg <= rd_data_in;
      else if (read_reg && sclk_fall)
        out_sr_reg <= {out_sr_reg[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data changes on falling sclk so the host samples on rising
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
    else if (!active || !read_reg)
    begin
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
    else if (sclk_fall && bit_cnt_reg >= INSTR_LAST_CNT)
    begin
      // Shifter moves on the same edge, so its top bit is always the next one
      sdo_out    <= out_sr_reg[7];
      sdo_oe_out <= 1'b1;
    end
  end

endmodule // serial_port_slave

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
(
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      sclk_out,
  output logic      csb_n_out,
  output logic      sdi_out,
  output logic      gate_pin_out
);
  // Serial clock stands low outside frames
  initial
  begin
    sclk_out     = 1'b0;
    csb_n_out    = 1'b1;
    sdi_out      = 1'b0;
    gate_pin_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Each sclk phase is 5 clk, above the 4 clk the device sampler needs
  task automatic xfer(input  logic        rd,
                      input  logic [14:0] addr,
                      input  logic [7:0]  wdata,
                      output logic [7:0]  rdata,
                      output logic        oe_seen);
    logic [23:0] frame;
    frame = {rd, addr, wdata};
    rdata = 8'h00;
    oe_seen = 1'b1;
    csb_n_out <= 1'b0;
    repeat (5) @(posedge clk_in);
    for (int i = 0; i < 24; i++)
    begin
      // Data line keeps toggling once the host has no bits left to send
      sdi_out <= (rd && i >= 16) ? ~sdi_out : frame[23-i];
      repeat (5) @(posedge clk_in);
      if (i >= 16)
        rdata[23-i] = sdo_in;
      if (i >= 16)
        oe_seen = oe_seen & sdo_oe_in;
      sclk_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (5) @(posedge clk_in);
    csb_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic set_pin(input logic level);
    gate_pin_out <= level;
  endtask
endmodule // spi_host_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tx_gate_pkg::*;
  logic       clk_in;
  logic       nrst_in;
  logic       sclk;
  logic       csb_n;
  logic       sdi;
  logic       gate_pin;
  logic       sdo;
  logic       sdo_oe;
  logic       in_gate;
  logic       out_gate;
  logic       nco_sel;
  logic [9:0] fs_code;
  logic [1:0] bias;
  logic [5:0] trim;
  int         num_errors;
  int         comparisons;

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  tx_gate_and_fullscale_regs u_tx_gate_and_fullscale_regs (
    .clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .csb_n_in(csb_n), .sdi_in(sdi),
    .tx_gate_pin_in(gate_pin), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .input_gate_out(in_gate), .output_gate_out(out_gate), .nco_reset_select_out(nco_sel),
    .fullscale_code_out(fs_code), .bias_powerdown_out(bias), .phase_trim_out(trim));

  spi_host_model u_spi_host_model (
    .clk_in(clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .sclk_out(sclk),
    .csb_n_out(csb_n), .sdi_out(sdi), .gate_pin_out(gate_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [14:0] addr, input logic [7:0] data);
    logic [7:0] unused_rd;
    logic       unused_oe;
    u_spi_host_model.xfer(1'b0, addr, data, unused_rd, unused_oe);
  endtask

  task automatic rd_check(input string what, input logic [14:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    logic       oe;
    u_spi_host_model.xfer(1'b1, addr, 8'h00, got, oe);
    check({what, " drive"}, 16'h0001, {15'h0000, oe});
    check(what, {8'h00, exp}, {8'h00, got});
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check("input_gate", 16'h0001, {15'h0000, in_gate});
    check("output_gate", 16'h0001, {15'h0000, out_gate});
    check("fullscale_code", 16'h03ff, {6'h00, fs_code});
    check("bias_powerdown", 16'h0003, {14'h0000, bias});
    check("phase_trim", 16'h0000, {10'h000, trim});
    rd_check("transmit_gate_control", TX_GATE_CONTROL_ADDR, 8'hc0);
    rd_check("dac_bias_powerdown", DAC_BIAS_POWERDOWN_ADDR, 8'h03);
    rd_check("fullscale_current_low", FULLSCALE_CURRENT_LOW_ADDR, 8'h03);
    rd_check("fullscale_current_high", FULLSCALE_CURRENT_HIGH_ADDR, 8'hff);
    rd_check("clock_phase_balance_trim", CLOCK_PHASE_TRIM_ADDR, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_fullscale;
    wr(FULLSCALE_CURRENT_HIGH_ADDR, 8'h80);
    wr(FULLSCALE_CURRENT_LOW_ADDR, 8'hfe);
    check("fullscale_code", 16'h0202, {6'h00, fs_code});
    rd_check("fullscale_current_low", FULLSCALE_CURRENT_LOW_ADDR, 8'h02);
    wr(15'h0050, 8'ha5);
    rd_check("unmapped", 15'h0050, 8'h00);
    $display("test_fullscale done");
  endtask

  // Code 0x202 left by the full-scale test
  task automatic test_gates;
    logic [7:0] ctrl [6] = '{8'h00, 8'hc0, 8'h02, 8'h84, 8'h45, 8'hff};
    logic       exp_in;
    logic       exp_out;
    logic [9:0] exp_fs;
    for (int k = 0; k < 6; k++)
    begin
      wr(TX_GATE_CONTROL_ADDR, ctrl[k]);
      rd_check("transmit_gate_control", TX_GATE_CONTROL_ADDR, ctrl[k] & 8'hcf);
      for (int p = 0; p < 2; p++)
      begin
        u_spi_host_model.set_pin(p[0]);
        repeat (6) @(posedge clk_in);
        exp_in  = ctrl[k][1] ? p[0] : ctrl[k][6];
        exp_out = ctrl[k][2] ? p[0] : ctrl[k][7];
        exp_fs  = (ctrl[k][0] && !p[0]) ? 10'h000 : 10'h202;
        check("input_gate", {15'h0000, exp_in}, {15'h0000, in_gate});
        check("output_gate", {15'h0000, exp_out}, {15'h0000, out_gate});
        check("fullscale_code", {6'h00, exp_fs}, {6'h00, fs_code});
        check("nco_reset_select", {15'h0000, ctrl[k][3]}, {15'h0000, nco_sel});
      end
    end
    $display("test_gates done");
  endtask

  task automatic test_bias_trim;
    wr(DAC_BIAS_POWERDOWN_ADDR, 8'hfe);
    check("bias_powerdown", 16'h0002, {14'h0000, bias});
    rd_check("dac_bias_powerdown", DAC_BIAS_POWERDOWN_ADDR, 8'h02);
    wr(DAC_BIAS_POWERDOWN_ADDR, 8'h01);
    check("bias_powerdown", 16'h0001, {14'h0000, bias});
    wr(CLOCK_PHASE_TRIM_ADDR, 8'he1);
    check("phase_trim", 16'h0021, {10'h000, trim});
    rd_check("clock_phase_balance_trim", CLOCK_PHASE_TRIM_ADDR, 8'h21);
    $display("test_bias_trim done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    nrst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    test_reset;
    test_fullscale;
    test_gates;
    test_bias_trim;
    complete_run;
  end

  // Hang guard well above the length of the whole sequence
  initial
  begin
    repeat (90000) @(posedge clk_in);
    num_errors++;
    complete_run;
  end
endmodule // testbench
